// file: common/tkrb_pkg.sv
// Shared constants for the touch key recalibration and burst scheduler
package tkrb_pkg;
  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int KEYS = 24;
  localparam int X_LINES = 8;
  localparam int Y_LINES = 3;
  localparam int CLK_KHZ = 125000;
  localparam int HALF_SEC_MS = 500;
  localparam int TICK_CYC = CLK_KHZ * HALF_SEC_MS;
  localparam int POS_RECAL_MS = 1000;
  localparam int POS_RECAL_TICKS = POS_RECAL_MS / HALF_SEC_MS;
  localparam int SLOT_BASE_US = 500;
  localparam int SLOT_STEP_US = 250;
  localparam int SLOT_BASE_CYC = CLK_KHZ * SLOT_BASE_US / 1000;
  localparam int SLOT_STEP_CYC = CLK_KHZ * SLOT_STEP_US / 1000;
  localparam int SYNC_WAIT_MS = 100;
  localparam int SYNC_WAIT_CYC = CLK_KHZ * SYNC_WAIT_MS;
  localparam int XFER_CYC = 4;
  localparam int PULSE_STEP = 16;
  localparam logic signed [16:0] POS_THRESHOLD = 17'sh00006;
  localparam logic [3:0] SPACING_MIN = 4'h1;
  localparam logic [3:0] SPACING_MAX = 4'hb;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] RECAL_OFS = 12'h008;
  localparam logic [11:0] ACTIVE_OFS = 12'h00c;
  localparam logic [11:0] KEY_BASE_OFS = 12'h100;
  localparam int CTRL_ALIGN_BIT = 0;
  localparam int CTRL_SPACING_LSB = 8;
  localparam int STATUS_SYNC_ERR_BIT = 0;
  localparam int RECAL_ALL_BIT = 8;
  localparam int KEY_DELAY_LSB = 0;
  localparam int KEY_SETUP_LSB = 8;
  localparam int KEY_LIMIT_LSB = 16;
  localparam int SETUP_BURST_LSB = 4;
  localparam int SETUP_SUPPRESS_BIT = 6;
  localparam int SETUP_SCOPE_BIT = 7;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] NEG_RECAL_DELAY_RST = 8'h14;
  localparam logic [7:0] SETUP_RST = 8'h20;
  localparam logic [3:0] LIMIT_RST = 4'h2;
  localparam logic [3:0] SPACING_RST = 4'h1;
  typedef enum logic [1:0] {
    SCH_SCAN = 2'b00,
    SCH_WAIT_SYNC = 2'b01
  } tkrb_sched_t;
endpackage

// file: common/tkrb_burst_if.sv
// Burst request carrier between scheduler, engine and top
`timescale 1ns/100ps
interface tkrb_burst_if;
  logic start;
  logic [4:0] key;
  logic [6:0] pulses;
  logic scope;
  logic busy;
  modport sched (output start, output key, input busy);
  modport engine (input start, input key, input pulses, input scope, output busy);
  modport ctl (input start, input key, input busy, output pulses, output scope);
endinterface

// file: core/tkrb_slot_sched.sv
// Burst timeslot and line-frequency alignment scheduler
`timescale 1ns/100ps
module tkrb_slot_sched #(
  parameter int N_KEYS = tkrb_pkg::KEYS,
  parameter int SYNC_WAIT = tkrb_pkg::SYNC_WAIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N_KEYS-1:0] key_enabled,
  input wire logic [3:0] burst_slot_spacing,
  input wire logic line_freq_align_en,
  input wire logic sync_level,
  tkrb_burst_if.sched bus,
  output logic sync_timeout
);
  tkrb_pkg::tkrb_sched_t state;
  logic [23:0] slot_cnt;
  logic [23:0] wait_cnt;
  logic [23:0] slot_len;
  logic [3:0] code;
  logic sync_prev;
  logic fall;
  logic [4:0] next_key;
  logic next_found;
  logic [4:0] first_key;
  logic first_found;
  logic begun;
  always_comb begin
    code = burst_slot_spacing;
    if (code < tkrb_pkg::SPACING_MIN) code = tkrb_pkg::SPACING_MIN;
    if (code > tkrb_pkg::SPACING_MAX) code = tkrb_pkg::SPACING_MAX;
    // (RQ19)
    slot_len = 24'(tkrb_pkg::SLOT_BASE_CYC + (int'(code) - 1) * tkrb_pkg::SLOT_STEP_CYC);
  end
  // Disabled keys never occupy a slot
  always_comb begin
    next_key = '0;
    next_found = 1'b0;
    first_key = '0;
    first_found = 1'b0;
    for (int k = N_KEYS - 1; k >= 0; k--) begin
      if (key_enabled[k]) begin // (RQ20)
        first_key = 5'(k);
        first_found = 1'b1;
        if (k > int'(bus.key)) begin
          next_key = 5'(k);
          next_found = 1'b1;
        end
      end
    end
  end
  assign fall = sync_prev && !sync_level; // (RQ15)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_prev <= 1'b1;
    end else begin
      sync_prev <= sync_level;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tkrb_pkg::SCH_SCAN;
      slot_cnt <= '0;
      wait_cnt <= '0;
      bus.start <= 1'b0;
      bus.key <= '0;
      sync_timeout <= 1'b0;
      begun <= 1'b0;
    end else begin
      bus.start <= 1'b0;
      sync_timeout <= 1'b0;
      if (slot_cnt != '0) slot_cnt <= slot_cnt - 24'h000001;
      case (state)
        tkrb_pkg::SCH_SCAN: begin
          if (slot_cnt == '0 && !bus.busy && first_found) begin
            begun <= 1'b1;
            // The first scan after reset opens at the lowest enabled key
            if (next_found && begun && !bus.start) begin
              bus.key <= next_key; // (RQ18)
              bus.start <= 1'b1;
              slot_cnt <= slot_len - 24'h000001;
            end else if (line_freq_align_en) begin
              state <= tkrb_pkg::SCH_WAIT_SYNC;
              wait_cnt <= 24'(SYNC_WAIT - 1);
            end else begin
              bus.key <= first_key;
              bus.start <= 1'b1;
              slot_cnt <= slot_len - 24'h000001;
            end
          end
        end
        tkrb_pkg::SCH_WAIT_SYNC: begin
          if (wait_cnt != '0) wait_cnt <= wait_cnt - 24'h000001;
          if (fall || wait_cnt == '0) begin
            sync_timeout <= !fall; // (RQ16)
            state <= tkrb_pkg::SCH_SCAN;
            bus.key <= first_key; // (RQ15)
            bus.start <= first_found;
            slot_cnt <= slot_len - 24'h000001;
          end
        end
        default: state <= tkrb_pkg::SCH_SCAN;
      endcase
    end
  end
endmodule // tkrb_slot_sched

// file: core/tkrb_burst_engine.sv
// Charge-transfer burst pulse generator for one key at a time
`timescale 1ns/100ps
module tkrb_burst_engine #(
  parameter int X_N = tkrb_pkg::X_LINES,
  parameter int Y_N = tkrb_pkg::Y_LINES
) (
  input wire logic hclk,
  input wire logic hresetn,
  tkrb_burst_if.engine bus,
  output logic [X_N-1:0] x_pulse,
  output logic [Y_N-1:0] y_enable,
  output logic scope_sync,
  output logic burst_done
);
  logic [6:0] left;
  logic [2:0] phase;
  logic [2:0] xsel;
  logic [1:0] ysel;
  logic active;
  assign bus.busy = active;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active <= 1'b0;
      left <= '0;
      phase <= '0;
      xsel <= '0;
      ysel <= '0;
      x_pulse <= '0;
      y_enable <= '0;
      scope_sync <= 1'b0;
      burst_done <= 1'b0;
    end else begin
      burst_done <= 1'b0;
      x_pulse <= '0;
      if (!active && bus.start) begin
        active <= 1'b1;
        left <= bus.pulses;
        phase <= '0;
        xsel <= bus.key[2:0];
        ysel <= bus.key[4:3];
        y_enable <= Y_N'(1) << bus.key[4:3];
        scope_sync <= bus.scope; // (RQ13)
      end else if (active) begin
        // One X pulse per transfer while the Y line captures (RQ7)
        if (phase == '0) x_pulse <= X_N'(1) << xsel;
        phase <= (phase == 3'(tkrb_pkg::XFER_CYC - 1)) ? 3'h0 : phase + 3'h1;
        if (phase == 3'(tkrb_pkg::XFER_CYC - 1)) begin
          left <= left - 7'h01;
          if (left == 7'h01) begin
            active <= 1'b0;
            y_enable <= '0;
            scope_sync <= 1'b0;
            burst_done <= 1'b1;
          end
        end
      end
    end
  end
endmodule // tkrb_burst_engine

// file: core/tkrb_scan_ctrl.sv
// Top: per-key recalibration timers, suppression and register slave
//
// Function
// (RQ1) Recalibrate key after detection outlasts its delay
// (RQ2) Key works normally after recalibration, object present
// (RQ3) Delay zero: no auto recalibration, host still can
// (RQ4) Delay byte 0..254 in half seconds, never 255
// (RQ5) Recalibrate after positive excursion lasting full period
// (RQ6) Positive recalibration period fixed at one second
// (RQ7) Burst: X pulses with Y capturing, max 64
// (RQ8) Burst code selects 16/32/48/64, default 48
// (RQ9) Burst length configurable per key
// (RQ10) Suppress detection if other enabled key more negative
// (RQ11) Suppression over all keys, raw deviation only
// (RQ12) Suppression disabled by default on every key
// (RQ13) Scope pulse spans burst of enabled keys, default off
// (RQ14) Scope setting applies after reset or recalibration
// (RQ15) Align scans to falling sync edge, 100ms wait
// (RQ16) Missing sync: 100ms gap and error flag
// (RQ17) Sync source gives clean buffered logic edges
// (RQ18) Bursts start at fixed global slot spacing
// (RQ19) Spacing code 1..11 maps 500us to 3ms
// (RQ20) Keys with zero integrator limit skip bursts
// (RQ21) Positive threshold fixed at six counts
// (RQ22) Setup byte: burst bits 5:4, suppress 6, scope 7
// (RQ23) Recalibration loads reference, clears state, restarts timers
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module tkrb_scan_ctrl #(
  parameter int N_KEYS = tkrb_pkg::KEYS,
  parameter int TICK = tkrb_pkg::TICK_CYC,
  parameter int SYNC_WAIT = tkrb_pkg::SYNC_WAIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_pin,
  input wire logic meas_valid,
  input wire logic [15:0] meas_value,
  input wire logic meas_touch,
  output logic [tkrb_pkg::X_LINES-1:0] x_pulse,
  output logic [tkrb_pkg::Y_LINES-1:0] y_enable,
  output logic scope_sync,
  output logic [N_KEYS-1:0] key_active
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] neg_recal_delay [N_KEYS];
  logic [7:0] key_setup [N_KEYS];
  logic [3:0] normal_integrator_limit [N_KEYS];
  logic [15:0] reference [N_KEYS];
  logic [15:0] last_meas [N_KEYS];
  logic signed [16:0] deviation [N_KEYS];
  logic [N_KEYS-1:0] touch;
  logic [N_KEYS-1:0] scope_latched;
  logic [N_KEYS-1:0] init_pend;
  logic [N_KEYS-1:0] key_enabled;
  logic [N_KEYS-1:0] cross_key_suppress_en;
  logic [N_KEYS-1:0] suppressed;
  logic [N_KEYS-1:0] host_recal;
  logic [N_KEYS-1:0] recal_now;
  logic line_freq_align_en;
  logic [3:0] burst_slot_spacing;
  logic sync_err;
  logic sync_timeout;
  logic burst_done;
  logic [4:0] meas_key;
  logic meas_armed;
  logic sync_ff1;
  logic sync_ff2;
  logic [25:0] tick_cnt;
  logic half_tick;
  logic [1:0] burst_len_code;
  tkrb_burst_if bif ();
  // ----------------------------------------------------------------
  // Sync pin synchroniser
  // ----------------------------------------------------------------
  // Edge choice relies on a clean driven edge from outside (RQ17)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_ff1 <= 1'b1;
      sync_ff2 <= 1'b1;
    end else begin
      sync_ff1 <= sync_pin;
      sync_ff2 <= sync_ff1;
    end
  end
  // ----------------------------------------------------------------
  // Half-second timebase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      half_tick <= 1'b0;
    end else begin
      half_tick <= (tick_cnt == 26'(TICK - 1));
      tick_cnt <= (tick_cnt == 26'(TICK - 1)) ? 26'h0000000 : tick_cnt + 26'h0000001;
    end
  end
  // ----------------------------------------------------------------
  // Scheduler and burst engine
  // ----------------------------------------------------------------
  always_comb begin
    burst_len_code = key_setup[bif.key][tkrb_pkg::SETUP_BURST_LSB +: 2]; // (RQ22)
    bif.pulses = 7'(tkrb_pkg::PULSE_STEP) * (7'(burst_len_code) + 7'h01); // (RQ8) (RQ9)
    bif.scope = scope_latched[bif.key];
  end
  tkrb_slot_sched #(
    .N_KEYS(N_KEYS),
    .SYNC_WAIT(SYNC_WAIT)
  ) u_sched (
    .hclk(hclk),
    .hresetn(hresetn),
    .key_enabled(key_enabled),
    .burst_slot_spacing(burst_slot_spacing),
    .line_freq_align_en(line_freq_align_en),
    .sync_level(sync_ff2),
    .bus(bif.sched),
    .sync_timeout(sync_timeout)
  );
  tkrb_burst_engine u_engine (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(bif.engine),
    .x_pulse(x_pulse),
    .y_enable(y_enable),
    .scope_sync(scope_sync),
    .burst_done(burst_done)
  );
  // Result of a burst belongs to the key that was just pulsed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_key <= '0;
      meas_armed <= 1'b0;
    end else begin
      if (burst_done) begin
        meas_key <= bif.key;
        meas_armed <= 1'b1;
      end else if (meas_valid) begin
        meas_armed <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Per-key state
  // ----------------------------------------------------------------
  for (genvar k = 0; k < N_KEYS; k++) begin : g_key
    logic [7:0] neg_cnt;
    logic [1:0] pos_cnt;
    logic pos_flag;
    logic hit;
    logic signed [16:0] rise;
    assign hit = meas_valid && meas_armed && (meas_key == 5'(k));
    assign rise = 17'(signed'({1'b0, meas_value})) - 17'(signed'({1'b0, reference[k]}));
    assign key_enabled[k] = (normal_integrator_limit[k] != 4'h0); // (RQ20)
    assign cross_key_suppress_en[k] = key_setup[k][tkrb_pkg::SETUP_SUPPRESS_BIT]; // (RQ22)
    always_comb begin
      recal_now[k] = host_recal[k]; // (RQ3)
      // Zero delay never expires on its own (RQ3)
      if (touch[k] && neg_recal_delay[k] != 8'h00 && neg_cnt >= neg_recal_delay[k]) begin
        recal_now[k] = 1'b1; // (RQ1) (RQ4)
      end
      if (pos_cnt == 2'(tkrb_pkg::POS_RECAL_TICKS)) begin
        recal_now[k] = 1'b1; // (RQ5) (RQ6)
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        neg_cnt <= '0;
        pos_cnt <= '0;
        pos_flag <= 1'b0;
      end else if (recal_now[k]) begin
        neg_cnt <= '0; // (RQ23)
        pos_cnt <= '0;
        pos_flag <= 1'b0;
      end else begin
        // No reference exists before the first measurement, so no excursion either
        if (hit && !init_pend[k]) pos_flag <= rise > tkrb_pkg::POS_THRESHOLD; // (RQ21)
        if (!touch[k]) neg_cnt <= '0;
        else if (half_tick && neg_cnt != 8'hff) neg_cnt <= neg_cnt + 8'h01; // (RQ1)
        // A dip below the level restarts the whole period
        if (!pos_flag) pos_cnt <= '0;
        else if (half_tick) pos_cnt <= pos_cnt + 2'h1; // (RQ5)
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        reference[k] <= '0;
        last_meas[k] <= '0;
        deviation[k] <= '0;
        touch[k] <= 1'b0;
        scope_latched[k] <= 1'b0;
        init_pend[k] <= 1'b1;
      end else begin
        if (hit) begin
          last_meas[k] <= meas_value;
          deviation[k] <= rise;
          touch[k] <= meas_touch;
        end
        // First measurement after reset sets the reference and scope option
        if (hit && init_pend[k]) begin
          reference[k] <= meas_value;
          deviation[k] <= '0;
          touch[k] <= 1'b0;
          init_pend[k] <= 1'b0;
          scope_latched[k] <= key_setup[k][tkrb_pkg::SETUP_SCOPE_BIT]; // (RQ14)
        end else if (recal_now[k]) begin
          reference[k] <= last_meas[k]; // (RQ23)
          deviation[k] <= '0;
          touch[k] <= 1'b0; // (RQ2)
          scope_latched[k] <= key_setup[k][tkrb_pkg::SETUP_SCOPE_BIT]; // (RQ14)
        end
      end
    end
    // Raw deviation only: thresholds and gains are not compensated
    always_comb begin
      suppressed[k] = 1'b0;
      for (int j = 0; j < N_KEYS; j++) begin
        if (j != k && cross_key_suppress_en[j] && deviation[j] < deviation[k]) begin
          suppressed[k] = cross_key_suppress_en[k]; // (RQ10) (RQ11)
        end
      end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        key_active[k] <= 1'b0;
      end else begin
        key_active[k] <= touch[k] && !suppressed[k]; // (RQ10)
      end
    end
  end
  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic ph_wr;
  logic ph_rd;
  logic [11:0] ph_addr;
  logic rd_wait;
  logic take;
  logic [31:0] rd_val;
  logic key_hit;
  logic [4:0] key_idx;
  assign take = hsel && hready && htrans[1];
  assign hresp = 1'b0;
  assign key_idx = 5'(ph_addr[11:2] - 10'(tkrb_pkg::KEY_BASE_OFS >> 2));
  assign key_hit = (ph_addr >= tkrb_pkg::KEY_BASE_OFS) &&
    (ph_addr < 12'(tkrb_pkg::KEY_BASE_OFS + 4 * N_KEYS));
  always_comb begin
    rd_val = '0;
    if (key_hit) begin
      rd_val[tkrb_pkg::KEY_DELAY_LSB +: 8] = neg_recal_delay[key_idx];
      rd_val[tkrb_pkg::KEY_SETUP_LSB +: 8] = key_setup[key_idx];
      rd_val[tkrb_pkg::KEY_LIMIT_LSB +: 4] = normal_integrator_limit[key_idx];
    end else begin
      case (ph_addr)
        tkrb_pkg::CTRL_OFS: begin
          rd_val[tkrb_pkg::CTRL_ALIGN_BIT] = line_freq_align_en;
          rd_val[tkrb_pkg::CTRL_SPACING_LSB +: 4] = burst_slot_spacing;
        end
        tkrb_pkg::STATUS_OFS: rd_val[tkrb_pkg::STATUS_SYNC_ERR_BIT] = sync_err; // (RQ16)
        tkrb_pkg::ACTIVE_OFS: rd_val[N_KEYS-1:0] = key_active;
        default: rd_val = '0;
      endcase
    end
  end
  // Reads take one wait state so that read data leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= '0;
      rd_wait <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= '0;
    end else begin
      if (hreadyout && take) begin
        ph_wr <= hwrite;
        ph_rd <= !hwrite;
        ph_addr <= {haddr[11:2], 2'b00};
        hreadyout <= hwrite;
        rd_wait <= !hwrite;
      end else if (rd_wait) begin
        hrdata <= rd_val;
        hreadyout <= 1'b1;
        rd_wait <= 1'b0;
      end else if (hreadyout) begin
        ph_wr <= 1'b0;
        ph_rd <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic do_wr;
  assign do_wr = ph_wr && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_freq_align_en <= 1'b0;
      burst_slot_spacing <= tkrb_pkg::SPACING_RST; // (RQ19)
      host_recal <= '0;
      for (int k = 0; k < N_KEYS; k++) begin
        neg_recal_delay[k] <= tkrb_pkg::NEG_RECAL_DELAY_RST;
        key_setup[k] <= tkrb_pkg::SETUP_RST; // (RQ8) (RQ12)
        normal_integrator_limit[k] <= tkrb_pkg::LIMIT_RST;
      end
    end else begin
      host_recal <= '0;
      if (do_wr && key_hit) begin
        // Value 255 is illegal; it is stored but must not be written (RQ4)
        neg_recal_delay[key_idx] <= hwdata[tkrb_pkg::KEY_DELAY_LSB +: 8];
        key_setup[key_idx] <= hwdata[tkrb_pkg::KEY_SETUP_LSB +: 8]; // (RQ9)
        normal_integrator_limit[key_idx] <= hwdata[tkrb_pkg::KEY_LIMIT_LSB +: 4];
      end else if (do_wr && ph_addr == tkrb_pkg::CTRL_OFS) begin
        line_freq_align_en <= hwdata[tkrb_pkg::CTRL_ALIGN_BIT];
        burst_slot_spacing <= hwdata[tkrb_pkg::CTRL_SPACING_LSB +: 4];
      end else if (do_wr && ph_addr == tkrb_pkg::RECAL_OFS) begin
        if (hwdata[tkrb_pkg::RECAL_ALL_BIT]) host_recal <= '1;
        else if (hwdata[4:0] < 5'(N_KEYS)) host_recal <= N_KEYS'(1) << hwdata[4:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Sync error flag
  // ----------------------------------------------------------------
  // Sticky error: a new timeout wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_err <= 1'b0;
    end else if (sync_timeout) begin
      sync_err <= 1'b1; // (RQ16)
    end else if (do_wr && ph_addr == tkrb_pkg::STATUS_OFS &&
        hwdata[tkrb_pkg::STATUS_SYNC_ERR_BIT]) begin
      sync_err <= 1'b0;
    end
  end
endmodule // tkrb_scan_ctrl

// file: dv/tkrb_scan_ctrl_assertions.sv
// Checker for burst framing and bus timing of the scan controller
`timescale 1ns/100ps
module tkrb_scan_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] x_pulse,
  input wire logic [2:0] y_enable,
  input wire logic scope_sync
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_X_IN_BURST: assert property (|x_pulse |-> |y_enable)
    else $error("x pulse outside burst");
  AST_ONE_HOT: assert property ($onehot0(x_pulse) && $onehot0(y_enable))
    else $error("x or y not one-hot");
  AST_X_SPACING: assert property (|x_pulse |=> !(|x_pulse) [*3])
    else $error("x pulses closer than one transfer");
  AST_Y_STABLE: assert property (|y_enable && |$past(y_enable) |-> $stable(y_enable))
    else $error("y line changed inside burst");
  AST_BURST_LEN: assert property ($rose(|y_enable) |-> ##[60:260] !(|y_enable))
    else $error("burst length out of range");
  AST_SCOPE_IN_BURST: assert property (scope_sync |-> |y_enable)
    else $error("scope pulse outside burst");
  AST_SCOPE_RISE: assert property ($rose(scope_sync) |-> $rose(|y_enable))
    else $error("scope pulse not at burst start");
  AST_SCOPE_HOLD: assert property (scope_sync |=> scope_sync || !(|y_enable))
    else $error("scope pulse dropped mid burst");
  AST_READ_WAIT: assert property (hsel && hready && htrans[1] && !hwrite && hreadyout
    |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule // tkrb_scan_ctrl_chk
bind tkrb_scan_ctrl tkrb_scan_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .x_pulse(x_pulse), .y_enable(y_enable), .scope_sync(scope_sync));

// file: dv/tkrb_matrix_model.sv
// Model of the key matrix converter and the line sync source
`timescale 1ns/100ps
module tkrb_matrix_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] y_enable,
  output logic meas_valid,
  output logic [15:0] meas_value,
  output logic meas_touch,
  output logic sync_pin
);
  integer seed = 32'h1c60;
  logic [2:0] dly;
  logic was_on;
  // Clean buffered level with no edges, so only the timeout path runs
  assign sync_pin = 1'b1;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly <= 3'h0;
      was_on <= 1'b0;
      meas_valid <= 1'b0;
      meas_value <= 16'h0000;
      meas_touch <= 1'b0;
    end else begin
      was_on <= |y_enable;
      meas_valid <= (dly == 3'h1);
      dly <= (was_on && !(|y_enable)) ? 3'h3 : (dly != 3'h0) ? dly - 3'h1 : 3'h0;
      // Outside the valid pulse the data toggles every cycle, so it is never a stable value
      if (dly == 3'h1) begin
        meas_value <= 16'h0100 + 16'($random(seed) & 32'h3f);
        meas_touch <= 1'b1;
      end else begin
        meas_value <= ~meas_value;
        meas_touch <= ~meas_touch;
      end
    end
  end
endmodule // tkrb_matrix_model

// file: dv/testbench.sv
// Self-checking bench for the scan controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, meas_valid, meas_touch, sync_pin, scope_sync;
  logic [31:0] hrdata, e;
  logic [15:0] meas_value;
  logic [7:0] x_pulse;
  logic [2:0] y_enable;
  logic [23:0] key_active;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rq[$];
  logic [7:0] bq[$];
  logic rd_dp = 1'b0;
  logic was_on = 1'b0;
  logic scope_seen = 1'b0;
  logic [7:0] pulses = 8'h00;
  initial begin
    forever #4 hclk = ~hclk;
  end
  tkrb_scan_ctrl #(.TICK(100), .SYNC_WAIT(2000)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sync_pin(sync_pin),
    .meas_valid(meas_valid), .meas_value(meas_value), .meas_touch(meas_touch),
    .x_pulse(x_pulse), .y_enable(y_enable), .scope_sync(scope_sync),
    .key_active(key_active));
  tkrb_matrix_model u_model (.hclk(hclk), .hresetn(hresetn), .y_enable(y_enable),
    .meas_valid(meas_valid), .meas_value(meas_value), .meas_touch(meas_touch),
    .sync_pin(sync_pin));
  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Single word transfer; a read notes its expected word for the monitor
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    if (!w) rq.push_back(d);
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 100000) begin
      fail_count++;
      results();
    end
    if (rd_dp && hreadyout) begin
      e = rq.pop_front();
      `CHK("hrdata", e, hrdata)
    end
    if (hreadyout) rd_dp = hsel && htrans[1] && !hwrite;
    if (|y_enable) begin
      pulses += {7'h0, x_pulse[0]};
      scope_seen |= scope_sync;
    end else if (was_on) begin
      e = {24'h0, bq.pop_front()};
      `CHK("burst", e, {24'h0, scope_seen, pulses[6:0]})
      pulses = 8'h00;
      scope_seen = 1'b0;
    end
    was_on = |y_enable;
  end
  initial begin
    bq.push_back(8'h30);
    bq.push_back(8'hc0);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 12'h000, 32'h0000_0100);
    bus(0, 12'h100, 32'h0002_2014);
    bus(0, 12'h004, 32'h0);
    bus(0, 12'h0f0, 32'h0);
    for (int k = 1; k < 24; k++) bus(1, 12'h100 + 12'(4 * k), 32'h0000_2014);
    bus(1, 12'h100, 32'h0002_b014);
    bus(0, 12'h100, 32'h0002_b014);
    bus(1, 12'h000, 32'h0000_0101);
    bus(1, 12'h008, 32'h0);
    while (bq.size() != 0) @(posedge hclk);
    bus(0, 12'h004, 32'h1);
    bus(1, 12'h004, 32'h1);
    bus(0, 12'h004, 32'h0);
    bus(0, 12'h00c, 32'h0000_0001);
    repeat (2200) @(posedge hclk);
    bus(0, 12'h00c, 32'h0);
    repeat (4) @(posedge hclk);
    results();
  end
endmodule // testbench
